/* File: optical_sensor_config_port.sv */
/*
  Configuration and readback port of a reflective optical sensor: decodes
  command frames on the command/status pin, writes and verifies the
  configuration bank, starts calibration, reports its result on the same pin
  and sends the bank contents serially on the detect-output pin.
  Assumes a nonvolatile array with a busy flag raised the cycle after a write,
  and a calibration engine on the same clock that pulses cal_done.
*/
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RQ1: Read bank back after each write, compare.
// RQ2: Mismatch sets error flag; match clears it.
// RQ3: Writes and calibrate arrive on command pin.
// RQ4: Status mode drives calibration result on pin.
// RQ5: Read request sends all bank bits out.
// RQ6: Bit 5 inverts output; bit 4 selects push-pull.
// RQ7: Bits 3..0 select the comparator threshold level.
// RQ8: Manchester: rising mid-bit is one, falling zero.
// RQ9: Frames start 1100, then two-bit opcode.
// RQ10: Write data follows opcode, bit 5 first.
// RQ11: Response is 37 bits, start, error, contents.
// RQ12: Bad sync frames are dropped without effect.
module optical_sensor_config_port #(
  parameter int STATUS_HOLD_CYCLES = sensor_cfg_pkg::STATUS_HOLD_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       cal_stat_in,
  output var  logic       cal_stat_out,
  output var  logic       cal_stat_oe_n,
  output var  logic       det_out,
  output var  logic       det_oe_n,
  input  wire logic       comparator_trip,
  output var  logic [3:0] threshold_level,
  output var  logic       output_polarity_bit,
  output var  logic       driver_select_bit,
  output var  logic       cal_start,
  input  wire logic       cal_done,
  input  wire logic       trim_success_bit,
  input  wire logic [1:0] gain_step_field,
  input  wire logic [9:0] emitter_drive_count,
  output var  logic       nv_write,
  output var  logic [5:0] nv_wdata,
  input  wire logic       nv_busy,
  input  wire logic [5:0] nv_rdata,
  output var  logic       verify_error
);

  typedef enum logic [2:0] {
    ST_LOAD, ST_IDLE, ST_WRITE, ST_VERIFY, ST_CAL, ST_STATUS, ST_READ
  } port_state_t;

  localparam int READ_TOTAL = 2 * 37 * sensor_cfg_pkg::TX_HALF_CYCLES;

  port_state_t  state;
  logic [5:0]   output_and_threshold_config;
  logic [5:0]   written;
  logic [11:0]  frame;
  logic [3:0]   nbits;
  logic         status_level;
  logic [14:0]  status_cnt;
  logic [36:0]  tx_word;
  logic [5:0]   tx_left;
  logic         tx_phase;
  logic [10:0]  tx_cnt;
  logic         t1;
  logic         t2;
  logic         t3;
  logic         trip;
  logic         bit_valid;
  logic         bit_value;
  logic         frame_end;
  logic [16:0]  read_len;

  // ****************************************************************
  // Command reception
  // ****************************************************************
  // The receiver is held clear whenever the pin is ours or a command runs.
  manch_rx u_rx (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clear     (state != ST_IDLE),
    .line_raw  (cal_stat_in), // RQ3
    .bit_valid (bit_valid),
    .bit_value (bit_value),
    .frame_end (frame_end)
  );

  // Frame decode; anything but an exact 6 or 12 bit frame with sync is ignored.
  wire frame_done = frame_end && (state == ST_IDLE);
  wire short_ok   = (nbits == sensor_cfg_pkg::SHORT_FRAME_BITS)
                    && (frame[5:2] == sensor_cfg_pkg::SYNC_NIBBLE); // RQ9 RQ12
  wire long_ok    = (nbits == sensor_cfg_pkg::WRITE_FRAME_BITS)
                    && (frame[11:8] == sensor_cfg_pkg::SYNC_NIBBLE)
                    && (frame[7:6] == sensor_cfg_pkg::OPC_WRITE); // RQ9 RQ12
  wire do_read    = frame_done && short_ok && (frame[1:0] == sensor_cfg_pkg::OPC_READ);
  wire do_cal     = frame_done && short_ok && (frame[1:0] == sensor_cfg_pkg::OPC_CAL);
  wire do_write   = frame_done && long_ok; // RQ3
  wire bad_sync   = frame_done && (nbits >= sensor_cfg_pkg::SHORT_FRAME_BITS)
                    && (nbits <= sensor_cfg_pkg::WRITE_FRAME_BITS)
                    && (frame[5:2] != sensor_cfg_pkg::SYNC_NIBBLE)
                    && (frame[11:8] != sensor_cfg_pkg::SYNC_NIBBLE);

  // Bits shift in first-bit-first, so write data lands in frame[5:0] bit 5 first.
  always_ff @(posedge clock)
  begin
    if (sys_rst || (state != ST_IDLE) || frame_end)
    begin
      frame <= '0;
      nbits <= '0;
    end
    else if (bit_valid)
    begin
      frame <= {frame[10:0], bit_value}; // RQ10
      nbits <= (nbits == 4'hF) ? nbits : nbits + 4'h1;
    end
  end

  // ****************************************************************
  // Bank write, verify and command sequencing
  // ****************************************************************
  wire verify_done     = (state == ST_VERIFY) && !nv_busy;
  wire verify_mismatch = nv_rdata != written; // RQ1
  wire status_over     = status_cnt == 15'(STATUS_HOLD_CYCLES - 1);
  wire half_over       = tx_cnt == 11'(sensor_cfg_pkg::TX_HALF_CYCLES - 1);
  wire tx_last         = half_over && tx_phase && (tx_left == 6'h01);
  wire [36:0] rsp_word = {7'h00,
                          output_and_threshold_config,
                          emitter_drive_count,
                          gain_step_field,
                          trim_success_bit,
                          9'h000,
                          verify_error,
                          1'b0}; // RQ11

  // Main sequencer; the live configuration is CFG_RESET until the load after reset, then always what the array read back.
  always_ff @(posedge clock)
  begin
    nv_write  <= 1'b0;
    cal_start <= 1'b0;
    if (sys_rst)
    begin
      state                       <= ST_LOAD;
      output_and_threshold_config <= sensor_cfg_pkg::CFG_RESET;
      written                     <= '0;
      nv_wdata                    <= '0;
      verify_error                <= 1'b0;
      status_level                <= 1'b0;
      status_cnt                  <= '0;
      tx_word                     <= '0;
      tx_left                     <= '0;
      tx_phase                    <= 1'b0;
      tx_cnt                      <= '0;
    end
    else
    begin
      unique case (state)
        ST_LOAD:
        begin
          if (!nv_busy)
          begin
            output_and_threshold_config <= nv_rdata;
            state                       <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (do_write)
          begin
            nv_write <= 1'b1;
            nv_wdata <= frame[5:0];
            written  <= frame[5:0];
            state    <= ST_WRITE;
          end
          else if (do_read)
          begin
            tx_word  <= rsp_word; // RQ5
            tx_left  <= sensor_cfg_pkg::RSP_BITS;
            tx_phase <= 1'b0;
            tx_cnt   <= '0;
            state    <= ST_READ;
          end
          else if (do_cal)
          begin
            cal_start <= 1'b1; // RQ3
            state     <= ST_CAL;
          end
        end
        ST_WRITE:
          state <= ST_VERIFY; // RQ1
        ST_VERIFY:
        begin
          if (verify_done)
          begin
            verify_error                <= verify_mismatch; // RQ2
            output_and_threshold_config <= nv_rdata;
            state                       <= ST_IDLE;
          end
        end
        ST_CAL:
        begin
          if (cal_done)
          begin
            status_level <= trim_success_bit; // RQ4
            status_cnt   <= '0;
            state        <= ST_STATUS;
          end
        end
        ST_STATUS:
        begin
          status_cnt <= status_cnt + 15'h0001;
          if (status_over)
            state <= ST_IDLE;
        end
        ST_READ:
        begin
          tx_cnt <= half_over ? 11'h000 : tx_cnt + 11'h001;
          if (half_over)
          begin
            tx_phase <= ~tx_phase;
            if (tx_phase)
            begin
              tx_word <= {1'b0, tx_word[36:1]};
              tx_left <= tx_left - 6'h01;
            end
          end
          if (tx_last)
            state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // First half carries the inverse of the bit, second half the bit itself.
  wire tx_level     = tx_phase ? tx_word[0] : ~tx_word[0]; // RQ8
  wire normal_level = trip ^ output_and_threshold_config[sensor_cfg_pkg::CFG_POLARITY]; // RQ6
  wire pin_level    = (state == ST_READ) ? tx_level : normal_level;
  wire push_pull    = output_and_threshold_config[sensor_cfg_pkg::CFG_DRIVER];

  // Comparator crosses from the analog side, so it is filtered like a pin.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      t1            <= 1'b0;
      t2            <= 1'b0;
      t3            <= 1'b0;
      trip          <= 1'b0;
      det_out       <= 1'b0;
      det_oe_n      <= 1'b1;
      cal_stat_out  <= 1'b0;
      cal_stat_oe_n <= 1'b1;
    end
    else
    begin
      t1            <= comparator_trip;
      t2            <= t1;
      t3            <= t2;
      trip          <= (t2 == t3) ? t3 : trip;
      det_out       <= push_pull & pin_level; // RQ6
      det_oe_n      <= ~push_pull & pin_level; // RQ6
      cal_stat_out  <= status_level;
      cal_stat_oe_n <= state != ST_STATUS; // RQ4
    end
  end

  // Threshold level feeds the reference selector; higher codes trip higher.
  assign threshold_level     = output_and_threshold_config[3:0]; // RQ7
  assign output_polarity_bit = output_and_threshold_config[sensor_cfg_pkg::CFG_POLARITY];
  assign driver_select_bit   = output_and_threshold_config[sensor_cfg_pkg::CFG_DRIVER];

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Counts the cycles of each response so its total length can be checked.
  always_ff @(posedge clock)
  begin
    if (sys_rst || (state != ST_READ))
      read_len <= '0;
    else
      read_len <= read_len + 17'h00001;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_WRITE_VERIFIES: assert property (nv_write |=> state == ST_VERIFY) // RQ1
    else $error("Write not followed by a read-back compare.");
  AST_ERROR_FLAG: assert property (verify_done |=> verify_error == $past(verify_mismatch)) // RQ2
    else $error("Verify error flag does not match compare result.");
  AST_WRITE_DATA: assert property (do_write |=> nv_write && (nv_wdata == $past(frame[5:0]))) // RQ10
    else $error("Write frame data not passed to the array.");
  AST_CAL_START: assert property (do_cal |=> cal_start ##1 (state == ST_CAL)) // RQ3
    else $error("Calibrate frame did not start calibration.");
  AST_STATUS_PIN: assert property ((state == ST_CAL) && cal_done
      |=> ##1 !cal_stat_oe_n && (cal_stat_out == $past(trim_success_bit, 2))) // RQ4
    else $error("Status mode does not show calibration result.");
  AST_READ_PAYLOAD: assert property (do_read
      |=> (tx_word[29:24] == $past(output_and_threshold_config)) && !tx_word[0]
          && (tx_word[1] == $past(verify_error))) // RQ5
    else $error("Read response does not hold bank contents.");
  AST_READ_LENGTH: assert property ($fell(state == ST_READ) |-> read_len == 17'(READ_TOTAL)) // RQ11
    else $error("Read response length is not 37 bits.");
  AST_SYNC_REJECT: assert property (bad_sync
      |=> !nv_write && !cal_start && (state == ST_IDLE)) // RQ12
    else $error("Frame without sync was acted upon.");
  AST_POLARITY: assert property ($past(state != ST_READ) && $past(push_pull)
      |-> det_out == $past(normal_level)) // RQ6
    else $error("Push-pull output has wrong polarity.");
  AST_OPEN_DRAIN: assert property ($past(!push_pull) |-> !det_out) // RQ6
    else $error("Open-drain output drives high.");
  AST_THRESHOLD: assert property (verify_done |=> threshold_level == $past(nv_rdata[3:0])) // RQ7
    else $error("Threshold level not taken from the bank.");

  COV_WRITE: cover property (verify_done && !verify_mismatch);
  COV_READ: cover property ($fell(state == ST_READ));
  COV_CAL: cover property ((state == ST_STATUS) && status_over);
  COV_REJECT: cover property (bad_sync);

endmodule

`default_nettype wire

/* File: sensor_cfg_pkg.sv */
/*
  Shared constants of the optical sensor configuration port: clock and bit
  timing, frame layout, command codes and the positions of the configuration
  and read-response fields.
  Assumes a 250 MHz system clock and a host that keeps the serial link
  between 50 kb/s and 200 kb/s.
*/
`default_nettype none

package sensor_cfg_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_MHZ          = 250;
  localparam int TX_RATE_KBPS       = 100;
  localparam int TX_HALF_CYCLES     = (CLOCK_MHZ * 1000) / (TX_RATE_KBPS * 2);
  localparam int RX_MIN_RATE_KBPS   = 50;
  localparam int RX_MAX_BIT_CYCLES  = (CLOCK_MHZ * 1000) / RX_MIN_RATE_KBPS;
  localparam int STATUS_HOLD_US     = 100;
  localparam int STATUS_HOLD_CYCLES = STATUS_HOLD_US * CLOCK_MHZ;
  localparam int CNT_W              = 14;

  // ****************************************************************
  // Command frames
  // ****************************************************************
  localparam logic [3:0] SYNC_NIBBLE      = 4'hC;
  localparam logic [1:0] OPC_NOP          = 2'h0;
  localparam logic [1:0] OPC_READ         = 2'h1;
  localparam logic [1:0] OPC_WRITE        = 2'h2;
  localparam logic [1:0] OPC_CAL          = 2'h3;
  localparam logic [3:0] SHORT_FRAME_BITS = 4'h6;
  localparam logic [3:0] WRITE_FRAME_BITS = 4'hC;

  // ****************************************************************
  // Configuration bank and read response
  // ****************************************************************
  localparam int         CFG_W          = 6;
  localparam int         CFG_POLARITY   = 5;
  localparam int         CFG_DRIVER     = 4;
  localparam int         CFG_THRESH_LSB = 0;
  localparam logic [5:0] CFG_RESET      = 6'h00;
  localparam logic [5:0] RSP_BITS       = 6'h25;
  localparam int         RSP_ERR        = 1;
  localparam int         RSP_CA         = 11;
  localparam int         RSP_AGC_LSB    = 12;
  localparam int         RSP_LED_LSB    = 14;
  localparam int         RSP_CFG_LSB    = 24;

endpackage

`default_nettype wire

/* File: manch_rx.sv */
/*
  Manchester receiver for the command/status pin. Learns the bit period from
  the two leading ones of the sync nibble and returns one pulse per bit and
  one pulse when the line goes quiet.
  Assumes the line idles high and the host bit rate is at least 50 kb/s.
*/
`timescale 1ns/1ns
`default_nettype none

module manch_rx (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clear,
  input  wire logic line_raw,
  output var  logic bit_valid,
  output var  logic bit_value,
  output var  logic frame_end
);

  localparam int W = sensor_cfg_pkg::CNT_W;

  typedef enum logic [1:0] {RX_IDLE, RX_LEARN, RX_RUN} rx_state_t;

  rx_state_t      state;
  logic           s1;
  logic           s2;
  logic           s3;
  logic           line;
  logic           line_d;
  logic           armed;
  logic [W-1:0]   cnt;
  logic [W-1:0]   period;

  // ****************************************************************
  // Edge detection and bit window
  // ****************************************************************
  // Edges closer than three quarters of a bit are boundary edges and are skipped.
  wire        rise      = line & ~line_d;
  wire        fall      = ~line & line_d;
  wire        any_edge  = line ^ line_d;
  wire [W-1:0] min_gap  = period - (period >> 2);
  wire [W-1:0] max_gap  = period + (period >> 1);
  wire        mid_edge  = any_edge && (cnt >= min_gap);
  wire        learn_out = cnt == W'(sensor_cfg_pkg::RX_MAX_BIT_CYCLES);

  // Three-stage synchroniser; a level counts once stages two and three agree.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s1     <= 1'b1;
      s2     <= 1'b1;
      s3     <= 1'b1;
      line   <= 1'b1;
      line_d <= 1'b1;
    end
    else
    begin
      s1     <= line_raw;
      s2     <= s1;
      s3     <= s2;
      line   <= (s2 == s3) ? s3 : line;
      line_d <= line;
    end
  end

  // Bit recovery: the level after a mid-bit edge is the bit.
  always_ff @(posedge clock)
  begin
    bit_valid <= 1'b0;
    frame_end <= 1'b0;
    if (sys_rst || clear)
    begin
      state     <= RX_IDLE;
      cnt       <= '0;
      period    <= '0;
      bit_value <= 1'b0;
      armed     <= 1'b0;
    end
    else
    begin
      cnt <= cnt + W'(1);
      unique case (state)
        // A rise starts a frame only after a fall seen while idle, so the pin
        // coming back high after a low status level is not taken for a bit.
        RX_IDLE:
        begin
          cnt <= '0;
          if (fall)
            armed <= 1'b1;
          if (rise && armed)
          begin
            state     <= RX_LEARN;
            armed     <= 1'b0;
            bit_valid <= 1'b1;
            bit_value <= 1'b1;
          end
        end
        RX_LEARN:
        begin
          if (rise)
          begin
            period    <= cnt;
            cnt       <= '0;
            state     <= RX_RUN;
            bit_valid <= 1'b1;
            bit_value <= 1'b1;
          end
          else if (learn_out)
          begin
            state     <= RX_IDLE;
            frame_end <= 1'b1;
          end
        end
        RX_RUN:
        begin
          if (mid_edge)
          begin
            cnt       <= '0;
            bit_valid <= 1'b1;
            bit_value <= line; // RQ8
          end
          else if (cnt > max_gap)
          begin
            state     <= RX_IDLE;
            frame_end <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: host_model.sv */
/*
  Host side of the sensor port: sends Manchester command frames on the
  command/status pin and samples read responses on the detect pin.
  Assumes the testbench resolves both pins with pull-ups.
*/
`timescale 1ns/1ns
`default_nettype none

module host_model #(
  parameter int HALF     = 625,
  parameter int RSP_HALF = sensor_cfg_pkg::TX_HALF_CYCLES
) (
  input  wire logic clock,
  input  wire logic det_pin,
  output var  logic cmd_drive
);
  // ****************************************************************
  // Frame sender
  // ****************************************************************
  // A released line is high, which is also how the receiver expects idle.
  initial cmd_drive = 1'b1;

  // Each bit is its inverse for a half period, then its true level.
  task automatic send_frame(input logic [11:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) // Sync, opcode, data, top bit first.
    begin
      cmd_drive <= ~bits[i];
      repeat (HALF) @(posedge clock);
      cmd_drive <= bits[i];
      repeat (HALF) @(posedge clock);
    end
    cmd_drive <= 1'b1;
  endtask

  // ****************************************************************
  // Response reader
  // ****************************************************************
  // Timing comes from the fall at mid start bit, so clock drift stays small.
  task automatic read_bits(input int n, output logic [15:0] word, output logic found);
    int t;
    word = '0;
    t = 0;
    while (det_pin !== 1'b0 && t < 8 * RSP_HALF)
    begin
      @(posedge clock);
      t++;
    end
    found = (det_pin === 1'b0);
    repeat (RSP_HALF / 2) @(posedge clock);
    for (int k = 0; k < n; k++)
    begin
      word[k] = det_pin;
      if (k < n - 1)
        repeat (2 * RSP_HALF) @(posedge clock);
    end
  endtask
endmodule

`default_nettype wire

/* File: tb_top.sv */
/*
  Self-checking testbench of the sensor configuration port, with array and
  calibration engine models.
  Assumes host_model and sensor_cfg_pkg are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam int HOLD = 20;
  logic       clock, sys_rst, comparator_trip, cal_done, trim_success_bit;
  logic       cal_stat_out, cal_stat_oe_n, det_out, det_oe_n, verify_error;
  logic       output_polarity_bit, driver_select_bit, cal_start, nv_write;
  logic       nv_busy, cmd_drive, cal_pin, det_pin, corrupt, found;
  logic [1:0] gain_step_field;
  logic [3:0] threshold_level, busy_cnt, cal_cnt;
  logic [5:0] nv_wdata, nv_rdata;
  logic [9:0] emitter_drive_count;
  logic [15:0] word;
  int         mismatches, checked, writes, cal_starts, t, w0, c0;

  // ****************************************************************
  // Pins and partners
  // ****************************************************************
  // Both pins have pull-ups; the host model drives 1 when it lets go.
  assign cal_pin = cal_stat_oe_n ? cmd_drive : cal_stat_out;
  assign det_pin = det_oe_n ? 1'b1 : det_out;
  assign nv_busy = (busy_cnt != 4'h0);
  assign cal_done = (cal_cnt == 4'h1);

  initial clock = 1'b0;
  always #2 clock = ~clock;

  // The array stores a write, optionally with one bit flipped, busy 8 cycles.
  always @(posedge clock)
  begin
    if (nv_write)
    begin
      nv_rdata <= corrupt ? (nv_wdata ^ 6'h01) : nv_wdata;
      busy_cnt <= 4'h8;
    end
    else if (busy_cnt != 4'h0)
      busy_cnt <= busy_cnt - 4'h1;
    cal_cnt <= (cal_start === 1'b1) ? 4'hA : ((cal_cnt != 4'h0) ? cal_cnt - 4'h1 : 4'h0);
    writes <= writes + int'(nv_write);
    cal_starts <= cal_starts + int'(cal_start);
  end

  host_model host_u (.clock(clock), .det_pin(det_pin), .cmd_drive(cmd_drive));

  optical_sensor_config_port #(.STATUS_HOLD_CYCLES(HOLD)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .cal_stat_in(cal_pin),
    .cal_stat_out(cal_stat_out), .cal_stat_oe_n(cal_stat_oe_n),
    .det_out(det_out), .det_oe_n(det_oe_n), .comparator_trip(comparator_trip),
    .threshold_level(threshold_level), .output_polarity_bit(output_polarity_bit),
    .driver_select_bit(driver_select_bit), .cal_start(cal_start), .cal_done(cal_done),
    .trim_success_bit(trim_success_bit), .gain_step_field(gain_step_field),
    .emitter_drive_count(emitter_drive_count), .nv_write(nv_write),
    .nv_wdata(nv_wdata), .nv_busy(nv_busy), .nv_rdata(nv_rdata),
    .verify_error(verify_error));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait on a write pulse, a calibration start or status mode.
  task automatic wait_on(input int w, input int limit);
    t = 0;
    while (((w == 0) ? nv_write : ((w == 1) ? cal_start : ~cal_stat_oe_n)) !== 1'b1
           && t < limit)
    begin
      @(posedge clock);
      #1;
      t++;
    end
    check("wait ended in time", 16'h1, 16'(t < limit));
  endtask

  // A clean write must also reach the outputs; a flipped one only the flag.
  task automatic write_cfg(input logic [5:0] val, input logic bad);
    corrupt = bad;
    host_u.send_frame({sensor_cfg_pkg::SYNC_NIBBLE, sensor_cfg_pkg::OPC_WRITE, val}, 12);
    wait_on(0, 6000);
    check("write data", 16'(val), 16'(nv_wdata));
    repeat (20) @(posedge clock);
    #1;
    check("verify flag", 16'(bad), 16'(verify_error));
    if (!bad)
      check("config", 16'(val), 16'({output_polarity_bit, driver_select_bit, threshold_level}));
    repeat (1300) @(posedge clock);
    $display("test write %h done", val);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    sys_rst = 1'b1;
    comparator_trip = 1'b1;
    trim_success_bit = 1'b1;
    gain_step_field = 2'h1;
    emitter_drive_count = 10'h3B;
    nv_rdata = 6'h25;
    busy_cnt = 4'h0;
    cal_cnt = 4'h0;
    corrupt = 1'b0;
    mismatches = 0;
    checked = 0;
    writes = 0;
    cal_starts = 0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clock);
    #1;
    check("config after reset", 16'h25, 16'({output_polarity_bit, driver_select_bit, threshold_level}));
    check("open drain inverted pin", 16'h0, 16'(det_pin));
    check("reset flag", 16'h0, 16'(verify_error));
    $display("test reset done");
    write_cfg(6'h15, 1'b1);
    write_cfg(6'h1B, 1'b0);
    check("push pull buffered pin", 16'h1, 16'({det_oe_n, det_out}));
    w0 = writes;
    c0 = cal_starts;
    host_u.send_frame(12'h037, 6);
    repeat (2600) @(posedge clock);
    check("no effect of bad sync", 16'(w0 + c0), 16'(writes + cal_starts));
    $display("test bad sync done");
    // A failed trim holds the pin low; its release must not start a frame.
    trim_success_bit <= 1'b0;
    host_u.send_frame({6'h0, sensor_cfg_pkg::SYNC_NIBBLE, sensor_cfg_pkg::OPC_CAL}, 6);
    wait_on(1, 6000);
    wait_on(2, 100);
    check("status level", 16'h0, 16'(cal_pin));
    t = 0;
    while (cal_stat_oe_n === 1'b0 && t < 100)
    begin
      @(posedge clock);
      #1;
      t++;
    end
    check("status hold", 16'h1, 16'(t >= HOLD - 1 && t <= HOLD + 1));
    $display("test calibrate done");
    trim_success_bit <= 1'b1;
    repeat (1300) @(posedge clock);
    host_u.send_frame({6'h0, sensor_cfg_pkg::SYNC_NIBBLE, sensor_cfg_pkg::OPC_READ}, 6);
    host_u.read_bits(14, word, found);
    check("response seen", 16'h1, 16'(found));
    check("response head", 16'h1800, word);
    $display("test read done");
    report_and_stop();
  end

  // The full run takes near 98500 cycles; the limit leaves a small margin.
  initial
  begin
    repeat (100000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
endmodule

`default_nettype wire
